/* File: rtl/cacsr_top.sv */
// charger converter control, status flags and adapter-removal alert
`timescale 1ns/1ns
`default_nettype none
module cacsr_top #(
  parameter int unsigned CONV_CYCLES = cacsr_pkg::CONV_CYCLES,
  parameter int unsigned REPEAT_CYCLES = cacsr_pkg::REPEAT_CYCLES,
  parameter int unsigned ALERT_CYCLES = cacsr_pkg::ALERT_CYCLES
) (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire cacsr_pkg::cacsr_wr_t HOST_WR,
  input wire logic HOST_RD_STB,
  input wire logic [7:0] HOST_RD_CMD,
  output logic [15:0] HOST_RD_DATA,
  output logic HOST_RD_VALID,
  input wire logic INPUT_GOOD_PIN,
  input wire logic OPTIMIZER_COMPLETE,
  input wire cacsr_pkg::cacsr_live_t LIVE_FLAGS,
  input wire cacsr_pkg::cacsr_fault_t FAULT_EVENTS,
  input wire logic SYSTEM_OVERVOLTAGE,
  input wire logic LOW_POWER_REQ,
  input wire logic FIRST_OPT_TOP,
  output logic CONV_ACTIVE,
  output logic CONV_RESULT_LOAD,
  output logic RANGE_HIGH,
  output logic [7:0] CHAN_ENABLE,
  output logic LOW_POWER,
  output logic CONVERTER_DISABLE,
  output logic PROCESSOR_HOT_ALERT_N_O,
  output logic PROCESSOR_HOT_ALERT_N_OE
);
  localparam int unsigned TW = cacsr_pkg::TIMER_W;
  localparam logic [TW-1:0] CONV_LOAD = TW'(CONV_CYCLES);
  localparam logic [TW-1:0] WAIT_LOAD = TW'(REPEAT_CYCLES - CONV_CYCLES);
  localparam logic [TW-1:0] ALERT_LOAD = TW'(ALERT_CYCLES);

  // decoded host strobes
  logic wr_ctrl; // write to converter_control
  logic wr_flags; // write to charger_state_flags
  logic wr_prof; // write to alert_profile_word
  logic rd_status; // read of charger_state_flags
  assign wr_ctrl = HOST_WR.stb && (HOST_WR.cmd == cacsr_pkg::CMD_CONV_CTRL);
  assign wr_flags = HOST_WR.stb && (HOST_WR.cmd == cacsr_pkg::CMD_STATE_FLAGS);
  assign wr_prof = HOST_WR.stb && (HOST_WR.cmd == cacsr_pkg::CMD_ALERT_PROFILE);
  assign rd_status = HOST_RD_STB && (HOST_RD_CMD == cacsr_pkg::CMD_STATE_FLAGS);

  // input-good pin, filtered
  logic src_s;
  cacsr_sync u_src_sync (
    .clk(CLK_SYS),
    .rst(RESET),
    .pin(INPUT_GOOD_PIN),
    .level(src_s)
  );

  // register state
  logic [15:0] ctrl_q; // converter_control word
  logic [15:0] ctrl_d;
  logic [cacsr_pkg::FAULT_W-1:0] fault_q; // latched faults
  logic [cacsr_pkg::FAULT_W-1:0] fault_d;
  logic sysovp_q; // latched system overvoltage
  logic sysovp_d;
  logic alert_en_q; // adapter removal alert enable
  logic alert_en_d;
  logic low_power_q; // low-power state
  logic low_power_d;
  logic src_prev_q; // last filtered source level
  logic [15:0] rd_data_q; // read answer
  logic [15:0] rd_data_d;
  logic rd_valid_q;
  logic [15:0] status_word; // live view of charger_state_flags
  logic adapter_fall; // source went away
  logic go_clr; // sequencer clears the go bit
  logic go_q;
  logic repeat_q;
  logic blocked; // converter held off

  assign go_q = ctrl_q[cacsr_pkg::CC_GO_BIT];
  assign repeat_q = ctrl_q[cacsr_pkg::CC_REPEAT_BIT];
  assign adapter_fall = src_prev_q && !src_s;
  assign blocked = low_power_q || sysovp_q;

  // status word assembly, reserved bits read zero
  always_comb begin
    status_word = cacsr_pkg::WORD_ZERO;
    status_word[cacsr_pkg::ST_SRC_BIT] = src_s;
    status_word[cacsr_pkg::ST_OPT_BIT] = OPTIMIZER_COMPLETE;
    // bit 12 is input voltage regulation, bit 11 input current regulation
    status_word[cacsr_pkg::ST_LIVE_LSB +: 5] = LIVE_FLAGS;
    status_word[cacsr_pkg::ST_FAULT_LSB +: cacsr_pkg::FAULT_W] = fault_q;
    status_word[cacsr_pkg::ST_SYSOVP_BIT] = sysovp_q;
  end

  // next values of the register group
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      // a host write wins over the automatic go clear
      ctrl_d = HOST_WR.data;
    end else if (go_clr) begin
      ctrl_d[cacsr_pkg::CC_GO_BIT] = 1'b0;
    end
    // event sets win over the read clear
    fault_d = FAULT_EVENTS | (rd_status ? '0 : fault_q);
    // clear by host zero write or unplug, fault presence wins
    sysovp_d = sysovp_q;
    if ((wr_flags && !HOST_WR.data[cacsr_pkg::ST_SYSOVP_BIT]) || adapter_fall) begin
      sysovp_d = 1'b0;
    end
    sysovp_d = sysovp_d || SYSTEM_OVERVOLTAGE;
    alert_en_d = wr_prof ? HOST_WR.data[cacsr_pkg::AP_ADAPTER_BIT] : alert_en_q;
    // asking for conversion on battery alone keeps us awake
    low_power_d = LOW_POWER_REQ && !(go_q && !src_s);
    // read answer, unmapped codes read zero
    rd_data_d = rd_data_q;
    if (HOST_RD_STB) begin
      case (HOST_RD_CMD)
        cacsr_pkg::CMD_STATE_FLAGS: begin
          rd_data_d = status_word;
        end
        cacsr_pkg::CMD_CONV_CTRL: begin
          rd_data_d = ctrl_q;
        end
        cacsr_pkg::CMD_ALERT_PROFILE: begin
          rd_data_d = cacsr_pkg::WORD_ZERO;
          rd_data_d[cacsr_pkg::AP_ADAPTER_BIT] = alert_en_q;
        end
        default: begin
          rd_data_d = cacsr_pkg::WORD_ZERO;
        end
      endcase
    end
  end

  // register group flops
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      ctrl_q <= cacsr_pkg::CONV_CTRL_RESET;
      fault_q <= '0;
      sysovp_q <= 1'b0;
      alert_en_q <= 1'b0;
      low_power_q <= 1'b0;
      src_prev_q <= 1'b0;
      rd_data_q <= cacsr_pkg::STATE_FLAGS_RESET;
      rd_valid_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      fault_q <= fault_d;
      sysovp_q <= sysovp_d;
      alert_en_q <= alert_en_d;
      low_power_q <= low_power_d;
      src_prev_q <= src_s;
      rd_data_q <= rd_data_d;
      rd_valid_q <= HOST_RD_STB;
    end
  end

  // conversion and repeat timers
  cacsr_pkg::cacsr_conv_state_t state_q;
  cacsr_pkg::cacsr_conv_state_t state_d;
  logic conv_start;
  logic wait_start;
  logic conv_done;
  logic wait_done;
  logic result_d;
  logic result_q;

  cacsr_timer #(.W(TW)) u_conv_tmr (
    .clk(CLK_SYS),
    .rst(RESET),
    .start(conv_start),
    .stop(state_d != cacsr_pkg::CS_CONVERT),
    .load(CONV_LOAD),
    .busy(),
    .done(conv_done)
  );

  cacsr_timer #(.W(TW)) u_wait_tmr (
    .clk(CLK_SYS),
    .rst(RESET),
    .start(wait_start),
    .stop(state_d != cacsr_pkg::CS_WAIT),
    .load(WAIT_LOAD),
    .busy(),
    .done(wait_done)
  );

  // sequencer next state
  always_comb begin
    state_d = state_q;
    conv_start = 1'b0;
    wait_start = 1'b0;
    go_clr = 1'b0;
    result_d = 1'b0;
    case (state_q)
      cacsr_pkg::CS_IDLE: begin
        // a pending go waits out low power or overvoltage
        if (go_q && !blocked) begin
          state_d = cacsr_pkg::CS_CONVERT;
          conv_start = 1'b1;
        end
      end
      cacsr_pkg::CS_CONVERT: begin
        if (blocked || !go_q) begin
          state_d = cacsr_pkg::CS_IDLE;
        end else if (conv_done) begin
          result_d = 1'b1;
          if (repeat_q) begin
            state_d = cacsr_pkg::CS_WAIT;
            wait_start = 1'b1;
          end else begin
            state_d = cacsr_pkg::CS_IDLE;
            go_clr = 1'b1;
          end
        end
      end
      cacsr_pkg::CS_WAIT: begin
        if (blocked || !go_q) begin
          state_d = cacsr_pkg::CS_IDLE;
        end else if (!repeat_q) begin
          // leaving repeat mode ends the series
          state_d = cacsr_pkg::CS_IDLE;
          go_clr = 1'b1;
        end else if (wait_done) begin
          state_d = cacsr_pkg::CS_CONVERT;
          conv_start = 1'b1;
        end
      end
      default: begin
        state_d = cacsr_pkg::CS_IDLE;
      end
    endcase
  end

  // sequencer flops
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      state_q <= cacsr_pkg::CS_IDLE;
      result_q <= 1'b0;
    end else begin
      state_q <= state_d;
      result_q <= result_d;
    end
  end

  // adapter removal alert pulse
  logic alert_fire;
  logic alert_busy;
  assign alert_fire = adapter_fall && alert_en_q && !FIRST_OPT_TOP;
  cacsr_timer #(.W(TW)) u_alert_tmr (
    .clk(CLK_SYS),
    .rst(RESET),
    .start(alert_fire),
    .stop(1'b0),
    .load(ALERT_LOAD),
    .busy(alert_busy),
    .done()
  );

  // outputs; alert pin is open drain, only ever pulled low
  assign HOST_RD_DATA = rd_data_q;
  assign HOST_RD_VALID = rd_valid_q;
  assign CONV_ACTIVE = (state_q == cacsr_pkg::CS_CONVERT);
  assign CONV_RESULT_LOAD = result_q;
  assign RANGE_HIGH = ctrl_q[cacsr_pkg::CC_RANGE_BIT];
  // bit 0 is battery voltage, the first result read back
  assign CHAN_ENABLE = ctrl_q[cacsr_pkg::CC_CHAN_LSB +: cacsr_pkg::CHAN_W];
  assign LOW_POWER = low_power_q;
  assign CONVERTER_DISABLE = sysovp_q;
  assign PROCESSOR_HOT_ALERT_N_O = 1'b0;
  assign PROCESSOR_HOT_ALERT_N_OE = alert_busy;

  // helper: cycles spent in the current conversion
  logic [TW-1:0] conv_age_q;
  logic [TW-1:0] conv_age_d;
  always_comb begin
    conv_age_d = CONV_ACTIVE ? conv_age_q + TW'(1) : '0;
  end
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      conv_age_q <= '0;
    end else begin
      conv_age_q <= conv_age_d;
    end
  end

  // checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);

  sequence s_conv_end;
    CONV_ACTIVE && conv_done && !blocked && go_q && !wr_ctrl;
  endsequence
  sequence s_alert_cause;
    adapter_fall && alert_en_q && !FIRST_OPT_TOP;
  endsequence

  a_single_shot_end: assert property (s_conv_end ##0 !repeat_q
    |=> !go_q && !CONV_ACTIVE ##0 CONV_RESULT_LOAD)
    else $error("single-shot set did not end");
  a_repeat_wait: assert property (s_conv_end ##0 repeat_q
    |=> state_q == cacsr_pkg::CS_WAIT && go_q)
    else $error("repeat mode did not wait");
  a_conv_time: assert property (CONV_ACTIVE && conv_done
    |-> conv_age_q == TW'(CONV_CYCLES - 1))
    else $error("conversion length wrong");
  a_go_starts: assert property (state_q == cacsr_pkg::CS_IDLE && go_q && !blocked
    |=> CONV_ACTIVE)
    else $error("go did not start conversion");
  a_range_write: assert property (wr_ctrl |=> RANGE_HIGH == $past(HOST_WR.data[13]))
    else $error("range bit not stored");
  a_chan_write: assert property (wr_ctrl |=> CHAN_ENABLE == $past(HOST_WR.data[7:0]))
    else $error("channel enables not stored");
  a_low_power_idle: assert property (LOW_POWER |=> !CONV_ACTIVE)
    else $error("converter ran in low power");
  a_lp_exit: assert property (go_q && !src_s |=> !LOW_POWER)
    else $error("low power not left");
  a_src_read: assert property (rd_status
    |=> HOST_RD_VALID && HOST_RD_DATA[15] == $past(src_s))
    else $error("source flag misread");
  a_fault_hold: assert property (!rd_status
    |=> (fault_q & $past(fault_q)) == $past(fault_q))
    else $error("fault flag dropped early");
  a_fault_report: assert property (rd_status ##0 FAULT_EVENTS == '0
    |=> HOST_RD_DATA[7:5] == $past(fault_q) && fault_q == '0)
    else $error("fault read or clear wrong");
  a_alert_pulse: assert property (s_alert_cause |=> PROCESSOR_HOT_ALERT_N_OE && !PROCESSOR_HOT_ALERT_N_O)
    else $error("alert not pulled low");
  a_alert_gate: assert property (!PROCESSOR_HOT_ALERT_N_OE && (FIRST_OPT_TOP || !alert_en_q)
    |=> !PROCESSOR_HOT_ALERT_N_OE)
    else $error("alert pulsed while gated");
  a_sysovp_block: assert property (SYSTEM_OVERVOLTAGE
    |=> CONVERTER_DISABLE ##1 !CONV_ACTIVE)
    else $error("overvoltage did not block");
endmodule : cacsr_top
`default_nettype wire

/* File: inc/cacsr_pkg.sv */
// constants, field layout and carrier types of the charger control and status bank
package cacsr_pkg;
  // clock and times
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned CONV_TIME_MS = 10;
  localparam int unsigned REPEAT_TIME_S = 1;
  localparam int unsigned ALERT_PULSE_US = 10;
  localparam int unsigned CONV_CYCLES = CONV_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned REPEAT_CYCLES = REPEAT_TIME_S * CLK_HZ;
  localparam int unsigned ALERT_CYCLES = ALERT_PULSE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned TIMER_W = 32;
  // command codes
  localparam logic [7:0] CMD_STATE_FLAGS = 8'h20;
  localparam logic [7:0] CMD_ALERT_PROFILE = 8'h34;
  localparam logic [7:0] CMD_CONV_CTRL = 8'h35;
  // converter_control layout
  localparam logic [15:0] CONV_CTRL_RESET = 16'h2000;
  localparam int unsigned CC_REPEAT_BIT = 15;
  localparam int unsigned CC_GO_BIT = 14;
  localparam int unsigned CC_RANGE_BIT = 13;
  localparam int unsigned CC_CHAN_LSB = 0;
  localparam int unsigned CHAN_W = 8;
  // charger_state_flags layout
  localparam logic [15:0] STATE_FLAGS_RESET = 16'h0000;
  localparam int unsigned ST_SRC_BIT = 15;
  localparam int unsigned ST_OPT_BIT = 14;
  localparam int unsigned ST_LIVE_LSB = 8;
  localparam int unsigned ST_FAULT_LSB = 5;
  localparam int unsigned ST_SYSOVP_BIT = 4;
  localparam int unsigned FAULT_W = 3;
  // alert_profile_word layout
  localparam int unsigned AP_ADAPTER_BIT = 0;
  localparam logic [15:0] WORD_ZERO = 16'h0000;

  // host write request
  typedef struct packed {
    logic stb;
    logic [7:0] cmd;
    logic [15:0] data;
  } cacsr_wr_t;

  // live conditions from the charger core, bits 12 down to 8
  typedef struct packed {
    logic input_voltage_regulating;
    logic input_current_regulating;
    logic fast_phase;
    logic precharge_phase;
    logic reverse_supply;
  } cacsr_live_t;

  // fault events, bits 7 down to 5
  typedef struct packed {
    logic input_overvoltage;
    logic battery_overcurrent;
    logic input_overcurrent;
  } cacsr_fault_t;

  // conversion sequencer states
  typedef enum logic [1:0] {CS_IDLE, CS_CONVERT, CS_WAIT} cacsr_conv_state_t;
endpackage : cacsr_pkg

/* File: rtl/cacsr_sync.sv */
// three-flop pin synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module cacsr_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic pin,
  output logic level
);
  logic s1_q; // first stage, read only by s2
  logic s2_q;
  logic s3_q;
  logic level_q;
  logic level_d;

  // accept a change only once stages two and three agree
  always_comb begin
    level_d = (s2_q == s3_q) ? s3_q : level_q;
  end

  // shift chain and filtered level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_q <= level_d;
    end
  end

  assign level = level_q;
endmodule : cacsr_sync
`default_nettype wire

/* File: rtl/cacsr_timer.sv */
// loadable down-counter with busy level and done pulse
`timescale 1ns/1ns
`default_nettype none
module cacsr_timer #(
  parameter int unsigned W = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic stop,
  input wire logic [W-1:0] load,
  output logic busy,
  output logic done
);
  localparam logic [W-1:0] ONE = W'(1);
  localparam logic [W-1:0] ZERO = W'(0);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  // start beats stop, so a restart in the stopping cycle is kept
  always_comb begin
    cnt_d = cnt_q;
    if (start) begin
      cnt_d = load;
    end else if (stop) begin
      cnt_d = ZERO;
    end else if (cnt_q != ZERO) begin
      cnt_d = cnt_q - ONE;
    end
  end

  // count register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= ZERO;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // done lands load minus one cycles after the start edge
  assign busy = (cnt_q != ZERO);
  assign done = (cnt_q == ONE);
endmodule : cacsr_timer
`default_nettype wire

/* File: dv/cacsr_host.sv */
// host model: issues whole command-word writes and reads on the register port
`timescale 1ns/1ns
`default_nettype none
module cacsr_host (
  input wire logic clk,
  output var cacsr_pkg::cacsr_wr_t wr_o,
  output var logic rd_stb,
  output var logic [7:0] rd_cmd,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid
);
  // idle bus at time zero
  initial begin
    wr_o = '0;
    rd_stb = 1'b0;
    rd_cmd = 8'h00;
  end

  // one word per write; released fields show the inverse, not stale values
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(negedge clk);
    wr_o = '{stb: 1'b1, cmd: c, data: d};
    @(negedge clk);
    wr_o = '{stb: 1'b0, cmd: ~c, data: ~d};
  endtask : wr

  // answer taken half a cycle after the taking edge, while valid stands
  task automatic rd(input logic [7:0] c, output logic [15:0] d, output logic v);
    @(negedge clk);
    rd_stb = 1'b1;
    rd_cmd = c;
    @(negedge clk);
    rd_stb = 1'b0;
    rd_cmd = ~c;
    v = rd_valid;
    d = rd_data;
  endtask : rd
endmodule : cacsr_host
`default_nettype wire

/* File: dv/cacsr_top_tb.sv */
// self-checking bench of the charger control and status bank
`timescale 1ns/1ns
`default_nettype none
module cacsr_top_tb;
  localparam int unsigned NC = 20; // short conversion set
  localparam int unsigned NR = 100; // short repeat period
  localparam int unsigned NA = 5; // short alert pulse
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic pin = 1'b0, opt = 1'b0, sysovp = 1'b0, lp_req = 1'b0, top = 1'b0;
  cacsr_pkg::cacsr_live_t live = '0;
  cacsr_pkg::cacsr_fault_t flt = '0;
  cacsr_pkg::cacsr_wr_t host_wr;
  logic rd_stb, rd_valid, act, load, range_hi, lp, cdis, ph_o, ph_oe, v;
  logic [7:0] rd_cmd, chan;
  logic [15:0] rd_data, d, q;
  logic [31:0] rs = 32'h0000_0024; // fixed seed
  int miscompares = 0, comparisons = 0, na, nl, n;
  int rises[$];

  // free-running system clock
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  cacsr_top #(.CONV_CYCLES(NC), .REPEAT_CYCLES(NR), .ALERT_CYCLES(NA)) cacsr_top_i (
    .CLK_SYS(clk_sys), .RESET(reset), .HOST_WR(host_wr), .HOST_RD_STB(rd_stb),
    .HOST_RD_CMD(rd_cmd), .HOST_RD_DATA(rd_data), .HOST_RD_VALID(rd_valid),
    .INPUT_GOOD_PIN(pin), .OPTIMIZER_COMPLETE(opt), .LIVE_FLAGS(live),
    .FAULT_EVENTS(flt), .SYSTEM_OVERVOLTAGE(sysovp), .LOW_POWER_REQ(lp_req),
    .FIRST_OPT_TOP(top), .CONV_ACTIVE(act), .CONV_RESULT_LOAD(load),
    .RANGE_HIGH(range_hi), .CHAN_ENABLE(chan), .LOW_POWER(lp),
    .CONVERTER_DISABLE(cdis), .PROCESSOR_HOT_ALERT_N_O(ph_o), .PROCESSOR_HOT_ALERT_N_OE(ph_oe));

  cacsr_host cacsr_host_i (.clk(clk_sys), .wr_o(host_wr), .rd_stb(rd_stb),
    .rd_cmd(rd_cmd), .rd_data(rd_data), .rd_valid(rd_valid));

  // xorshift step for repeatable stimulus
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  // expected status word: source, optimizer, live levels, faults, overvoltage
  function automatic logic [15:0] exp_st(input logic p, input logic o,
      input cacsr_pkg::cacsr_live_t l, input logic [2:0] f, input logic s);
    return {p, o, 1'b0, l, f, s, 4'h0};
  endfunction : exp_st

  // word compare, counted
  task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("BAD t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk

  // counts active and load cycles over a bounded window, noting each start
  task automatic watch(input int w);
    logic prev;
    prev = act;
    na = 0;
    nl = 0;
    rises.delete();
    for (int i = 0; i < w; i++) begin
      @(negedge clk_sys);
      if (act === 1'b1) na++;
      if (load === 1'b1) nl++;
      if (act === 1'b1 && prev !== 1'b1) rises.push_back(i);
      prev = act;
    end
  endtask : watch

  // single exit point with the verdict
  task automatic test_done();
    $display("counts: comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done

  // main sequence
  initial begin
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    reset = 1'b0;
    // reset values, unmapped code reads zero
    cacsr_host_i.rd(8'h35, q, v);
    chk(q, 16'h2000, "ctrl reset");
    chk({15'h0000, v}, 16'h0001, "read valid");
    chk({7'h00, range_hi, chan}, 16'h0100, "reset outputs");
    cacsr_host_i.rd(8'h20, q, v);
    chk(q, 16'h0000, "status reset");
    cacsr_host_i.rd(8'h34, q, v);
    chk(q, 16'h0000, "alert enable reset");
    cacsr_host_i.rd(8'h7E, q, v);
    chk(q, 16'h0000, "unmapped read");
    $display("test reset done");
    // control word: corners then random, go and repeat kept low
    for (int i = 0; i < 6; i++) begin
      rs = xs(rs);
      d = (i == 0) ? 16'h00FF : (i == 1) ? 16'h0000 : rs[15:0] & 16'h3FFF;
      cacsr_host_i.wr(8'h35, d);
      cacsr_host_i.rd(8'h35, q, v);
      chk(q, d, "ctrl readback");
      chk({7'h00, range_hi, chan}, {7'h00, d[13], d[7:0]}, "range and channels");
    end
    $display("test control done");
    // single shot: one set, then go self-clears
    cacsr_host_i.wr(8'h35, 16'h4001);
    watch(40);
    chk(16'(na), 16'(NC), "set length");
    chk(16'(nl), 16'h0001, "single load");
    cacsr_host_i.rd(8'h35, q, v);
    chk(q, 16'h0001, "go cleared");
    $display("test single done");
    // repeat mode: start spacing, then stop during the wait
    cacsr_host_i.wr(8'h35, 16'hC001);
    watch(150);
    chk(16'(rises.size()), 16'h0002, "repeat starts");
    chk(16'(nl), 16'h0002, "repeat loads");
    if (rises.size() == 2) chk(16'(rises[1] - rises[0]), 16'(NR), "period");
    // repeat bit dropped with go kept: series ends and go self-clears
    cacsr_host_i.wr(8'h35, 16'h4001);
    watch(120);
    chk(16'(na), 16'h0000, "series ended");
    cacsr_host_i.rd(8'h35, q, v);
    chk(q, 16'h0001, "go cleared after series");
    $display("test repeat done");
    // low power: converter held idle, then battery-only start exits
    pin = 1'b1;
    lp_req = 1'b1;
    repeat (6) @(negedge clk_sys);
    chk({15'h0000, lp}, 16'h0001, "low power on");
    cacsr_host_i.wr(8'h35, 16'h4001); // small range when on battery
    watch(30);
    chk(16'(na), 16'h0000, "idle in low power");
    pin = 1'b0;
    repeat (6) @(negedge clk_sys);
    chk({15'h0000, lp}, 16'h0000, "low power left");
    watch(40);
    chk(16'(nl), 16'h0001, "battery start");
    lp_req = 1'b0;
    $display("test low power done");
    // live status levels, random
    for (int i = 0; i < 5; i++) begin
      rs = xs(rs);
      pin = rs[8];
      opt = rs[9];
      live = (i == 0) ? 5'h1F : rs[4:0];
      repeat (6) @(negedge clk_sys);
      cacsr_host_i.rd(8'h20, q, v);
      chk(q, exp_st(pin, opt, live, 3'h0, 1'b0), "status");
    end
    $display("test status done");
    // each fault latches until read, then clears
    for (int i = 0; i < 3; i++) begin
      @(negedge clk_sys);
      flt = 3'h4 >> i;
      @(negedge clk_sys);
      flt = 3'h0;
      cacsr_host_i.rd(8'h20, q, v);
      chk(q, exp_st(pin, opt, live, 3'h4 >> i, 1'b0), "fault latched");
      cacsr_host_i.rd(8'h20, q, v);
      chk(q, exp_st(pin, opt, live, 3'h0, 1'b0), "fault cleared");
    end
    // faults present across the read are kept for the next one
    flt = 3'h7;
    cacsr_host_i.rd(8'h20, q, v);
    flt = 3'h0;
    chk(q, exp_st(pin, opt, live, 3'h7, 1'b0), "fault in read");
    cacsr_host_i.rd(8'h20, q, v);
    chk(q, exp_st(pin, opt, live, 3'h7, 1'b0), "recurrence kept");
    cacsr_host_i.rd(8'h20, q, v);
    chk(q, exp_st(pin, opt, live, 3'h0, 1'b0), "recurrence cleared");
    $display("test faults done");
    // system overvoltage: latch, block converter, host write clears
    pin = 1'b1;
    repeat (6) @(negedge clk_sys);
    sysovp = 1'b1;
    repeat (3) @(negedge clk_sys);
    sysovp = 1'b0;
    chk({15'h0000, cdis}, 16'h0001, "converter blocked");
    cacsr_host_i.rd(8'h20, q, v);
    chk(q, exp_st(pin, opt, live, 3'h0, 1'b1), "ovp latched");
    cacsr_host_i.wr(8'h35, 16'h4001);
    watch(30);
    chk(16'(na), 16'h0000, "no set in ovp");
    cacsr_host_i.wr(8'h20, 16'h0000);
    watch(40);
    chk(16'(nl), 16'h0001, "set after clear");
    chk({15'h0000, cdis}, 16'h0000, "converter freed");
    $display("test overvoltage done");
    // adapter removal alert: enabled with top bit low, none with it high
    cacsr_host_i.wr(8'h34, 16'hFFFF);
    cacsr_host_i.rd(8'h34, q, v);
    chk(q, 16'h0001, "alert enable");
    for (int k = 0; k < 2; k++) begin
      top = k[0];
      pin = 1'b1;
      repeat (6) @(negedge clk_sys);
      pin = 1'b0;
      n = 0;
      for (int i = 0; i < 20; i++) begin
        @(negedge clk_sys);
        if (ph_oe === 1'b1) n++;
      end
      chk(16'(n), (k == 0) ? 16'(NA) : 16'h0000, "alert length");
    end
    chk({15'h0000, ph_o}, 16'h0000, "alert drives low");
    $display("test alert done");
    // mid-run reset brings back the defaults
    reset = 1'b1;
    repeat (2) @(negedge clk_sys);
    reset = 1'b0;
    cacsr_host_i.rd(8'h35, q, v);
    chk(q, 16'h2000, "ctrl after reset");
    cacsr_host_i.rd(8'h34, q, v);
    chk(q, 16'h0000, "alert enable after reset");
    $display("test mid reset done");
    test_done();
  end
endmodule : cacsr_top_tb
`default_nettype wire
